// ### core/mbx_defs.svh
/*
 * Constants of the mailbox link: header word layout, mailbox size,
 * handle values, host register map, field positions and reset values.
 * Included by the package and by both ends; definitions only.
 */
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH

// Mailbox geometry: size in 32-bit words, capacity and header size in bytes
`define MBX_WORDS 16
`define MBX_AW 4
`define MBX_CAP_BYTES 32'h00000040
`define MBX_HDR_BYTES 32'h00000028

// Header word indices inside a mailbox
`define HDR_DEST 4'h0
`define HDR_SRC 4'h1
`define HDR_DESTID 4'h2
`define HDR_SRCID 4'h3
`define HDR_LEN 4'h4
`define HDR_ID 4'h5
`define HDR_STATE 4'h6
`define HDR_CMD 4'h7
`define HDR_EXT 4'h8
`define HDR_ROUT 4'h9
`define HDR_DATA0 4'hA

// Handles and command codes
`define CHANNEL_TOKEN 32'h00000020
`define ROUTER_HANDLE 32'h00000100
`define CMD_REGISTER 32'h00000F00
`define STS_OK 32'h00000000

// Host register offsets and window selectors
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_LEN 8'h08
`define OFF_IRQ_STAT 8'h0C
`define OFF_IRQ_MASK 8'h10
`define WIN_SEND 2'h1
`define WIN_RECV 2'h2

// Field positions
`define CTRL_SEND 0
`define CTRL_RDONE 1
`define CTRL_SERVER 2
`define CTRL_SERIAL 3
`define IRQ_RECV 0
`define IRQ_FREE 1
`define IRQ_REFUSED 2

// Reset values and timing counts
`define CTRL_RST 2'h0
`define LEN_RST 32'h00000000
`define MASK_RST 3'h0
`define RD_WAIT 2'h2

`endif

// ### core/mbx_pkg.sv
/*
 * Types shared by the two ends of the mailbox link.
 * Assumes mbx_defs.svh is on the include path.
 */
`include "mbx_defs.svh"
package mbx_pkg;
  typedef logic [31:0] word_t;
  typedef logic [`MBX_AW-1:0] widx_t;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_WAIT = 3'b010,
    DEV_CONF = 3'b100
  } dev_state_t;
endpackage

// ### core/mbx_link_if.sv
/*
 * Link between host end and device end: four handshake flags, a write
 * port into the send mailbox and a read port on the receive mailbox.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface mbx_link_if;
  import mbx_pkg::*;
  logic  host_send_cmd;
  logic  dev_send_ack;
  logic  dev_recv_cmd;
  logic  host_recv_ack;
  logic  sm_we;
  widx_t sm_addr;
  word_t sm_wdata;
  widx_t rm_addr;
  word_t rm_rdata;

  modport dev_end (
    input  host_send_cmd, host_recv_ack, sm_we, sm_addr, sm_wdata,
    input  rm_addr,
    output dev_send_ack, dev_recv_cmd, rm_rdata
  );
  modport host_end (
    output host_send_cmd, host_recv_ack, sm_we, sm_addr, sm_wdata,
    output rm_addr,
    input  dev_send_ack, dev_recv_cmd, rm_rdata
  );
endinterface

// ### core/mbx_dev_end.sv
/*
 * Device end: holds both mailboxes in flip-flops, routes each request
 * other than a registration to the local task under its own handles,
 * builds confirmations and indications. Assumes the host end and the task share hclk.
 */
`timescale 1ns/1ns
`include "mbx_defs.svh"
module mbx_dev_end (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  mbx_link_if.dev_end         link,
  output      logic           task_req,
  output      mbx_pkg::word_t task_cmd,
  output      mbx_pkg::word_t task_handle,
  output      mbx_pkg::word_t task_tag,
  output      mbx_pkg::word_t task_data,
  input  wire logic           task_done,
  input  wire mbx_pkg::word_t task_status,
  input  wire mbx_pkg::word_t task_rsp_handle,
  input  wire mbx_pkg::word_t task_rsp_tag,
  input  wire logic           ind_event,
  input  wire logic [2:0]     ind_num,
  input  wire mbx_pkg::word_t ind_cmd,
  output      logic           ind_ready
);
  import mbx_pkg::*;

  word_t      sm_mem [`MBX_WORDS];
  word_t      rm_mem [`MBX_WORDS];
  word_t      hdr    [`MBX_WORDS];
  dev_state_t st_reg;
  word_t      orig_src_reg;
  word_t      orig_srcid_reg;
  word_t      req_dest_reg;
  word_t      req_id_reg;
  word_t      req_cmd_reg;
  word_t      sts_reg;
  word_t      tag_reg;
  word_t      ind_cmd_reg;
  logic [7:0] ind_mask_reg;
  logic [2:0] ind_num_reg;
  logic       send_full;
  logic       recv_own;
  logic       take_ind;
  logic       accept;
  logic       is_rsp;
  logic       is_reg;
  logic       take_conf;
  logic       wr_hdr;
  logic       reply_ok;

  // Flag pairs decide who may touch each mailbox
  assign send_full = link.host_send_cmd ^ link.dev_send_ack;
  assign recv_own  = ~(link.dev_recv_cmd ^ link.host_recv_ack);
  // Indications go first, but only while idle; a busy task holds event delivery
  assign take_ind  = (st_reg == DEV_IDLE) && !ind_ready && recv_own;
  assign accept    = (st_reg == DEV_IDLE) && !take_ind && send_full;
  assign is_rsp    = sm_mem[`HDR_CMD][0];
  assign is_reg    = sm_mem[`HDR_CMD] == `CMD_REGISTER;
  assign take_conf = (st_reg == DEV_CONF) && recv_own;
  assign wr_hdr    = take_ind || take_conf;
  // Only a reply carrying our handle and current tag is ours
  assign reply_ok  = task_done && (task_rsp_handle == `ROUTER_HANDLE) &&
                     (task_rsp_tag == tag_reg);

  // Header of the packet placed into the receive mailbox
  always_comb begin
    for (int j = 0; j < `MBX_WORDS; j++) begin
      hdr[j] = '0;
    end
    if (take_ind) begin
      hdr[`HDR_DEST]   = `CHANNEL_TOKEN;
      hdr[`HDR_DESTID] = {29'h0, ind_num_reg};
      hdr[`HDR_CMD]    = {ind_cmd_reg[31:1], 1'b0};
    end else begin
      hdr[`HDR_DEST]   = req_dest_reg;
      hdr[`HDR_SRC]    = orig_src_reg;
      hdr[`HDR_SRCID]  = orig_srcid_reg;
      hdr[`HDR_ID]     = req_id_reg;
      hdr[`HDR_STATE]  = sts_reg;
      hdr[`HDR_CMD]    = req_cmd_reg + 32'h00000001;
    end
  end

  // Mailbox storage; host writes land only while the host owns it
  generate
    for (genvar i = 0; i < `MBX_WORDS; i++) begin : g_mem
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sm_mem[i] <= '0;
        end else if (link.sm_we && !send_full &&
                     link.sm_addr == widx_t'(i)) begin
          sm_mem[i] <= link.sm_wdata;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rm_mem[i] <= '0;
        end else if (wr_hdr) begin
          rm_mem[i] <= hdr[i];
        end
      end
    end
  endgenerate

  // Host read port; reads zero while the device still owns the box
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.rm_rdata <= '0;
    end else begin
      link.rm_rdata <= recv_own ? '0 : rm_mem[link.rm_addr];
    end
  end

  // Handshake flags: each toggle hands one mailbox to the other side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.dev_send_ack <= 1'b0;
      link.dev_recv_cmd <= 1'b0;
    end else begin
      if (accept) begin
        link.dev_send_ack <= ~link.dev_send_ack;
      end
      if (wr_hdr) begin
        link.dev_recv_cmd <= ~link.dev_recv_cmd;
      end
    end
  end

  // Packet engine; responses from the host are consumed silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= DEV_IDLE;
    end else begin
      unique case (st_reg)
        DEV_IDLE: if (accept && !is_rsp) begin
          st_reg <= is_reg ? DEV_CONF : DEV_WAIT;
        end
        DEV_WAIT: if (reply_ok) begin
          st_reg <= DEV_CONF;
        end
        DEV_CONF: if (take_conf) begin
          st_reg <= DEV_IDLE;
        end
      endcase
    end
  end

  // Request fields saved for the confirmation, status from the task
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orig_src_reg   <= '0;
      orig_srcid_reg <= '0;
      req_dest_reg   <= '0;
      req_id_reg     <= '0;
      req_cmd_reg    <= '0;
      sts_reg        <= '0;
      ind_mask_reg   <= '0;
    end else begin
      if (accept) begin
        orig_src_reg   <= sm_mem[`HDR_SRC];
        orig_srcid_reg <= sm_mem[`HDR_SRCID];
        req_dest_reg   <= sm_mem[`HDR_DEST];
        req_id_reg     <= sm_mem[`HDR_ID];
        req_cmd_reg    <= sm_mem[`HDR_CMD];
        sts_reg        <= `STS_OK;
      end
      if (accept && is_reg) begin
        ind_mask_reg <= sm_mem[`HDR_DATA0][7:0];
      end
      if (reply_ok) begin
        sts_reg <= task_status;
      end
    end
  end

  // Forward to the task under the router's own handle and tag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      task_req    <= 1'b0;
      task_cmd    <= '0;
      task_handle <= '0;
      task_tag    <= '0;
      task_data   <= '0;
      tag_reg     <= '0;
    end else begin
      task_req <= accept && !is_rsp && !is_reg;
      if (accept) begin
        task_cmd    <= sm_mem[`HDR_CMD];
        task_handle <= `ROUTER_HANDLE;
        task_tag    <= tag_reg;
        task_data   <= sm_mem[`HDR_DATA0];
      end
      // A new tag per reply makes stale answers miss the match
      if (reply_ok) begin
        tag_reg <= tag_reg + 32'h00000001;
      end
    end
  end

  // One pending indication; unregistered events are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_ready   <= 1'b1;
      ind_num_reg <= '0;
      ind_cmd_reg <= '0;
    end else if (take_ind) begin
      ind_ready <= 1'b1;
    end else if (ind_event && ind_ready && ind_mask_reg[ind_num]) begin
      ind_ready   <= 1'b0;
      ind_num_reg <= ind_num;
      ind_cmd_reg <= ind_cmd;
    end
  end

endmodule // mbx_dev_end

// ### core/mbx_host_end.sv
/*
 * Host end of the mailbox link: an AHB-Lite slave through which
 * software fills the send mailbox, reads the receive mailbox and
 * hands each mailbox over by toggling the host flags.
 * Assumes one AHB master, a single slave whose hreadyout is hready,
 * and a device end on the same clock.
 */
`timescale 1ns/1ns
`include "mbx_defs.svh"
module mbx_host_end (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire mbx_pkg::word_t hwdata,
  input  wire logic           hready,
  output      logic           hreadyout,
  output      mbx_pkg::word_t hrdata,
  output      logic           hresp,
  output      logic           irq,
  mbx_link_if.host_end        link
);
  import mbx_pkg::*;

  logic       ap;
  logic       ap_valid_reg;
  logic       ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [1:0] rd_cnt_reg;
  logic [1:0] ctrl_reg;
  word_t      len_reg;
  word_t      sh_dest_reg;
  word_t      sh_src_reg;
  word_t      sh_cmd_reg;
  word_t      rcv_cmd_reg;
  word_t      reg_rdata;
  logic       conf_pend_reg;
  logic       rsp_owed_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_set;
  logic       send_eq;
  logic       send_eq_prev_reg;
  logic       recv_diff;
  logic       recv_diff_prev_reg;
  logic       wr;
  logic       win_wr;
  logic       do_send;
  logic       do_rdone;
  logic       send_ok;
  logic       blocked;
  logic       refuse;
  logic       rd_clr;

  // Ownership as seen by the host; same clock, so no synchroniser
  assign send_eq   = ~(link.host_send_cmd ^ link.dev_send_ack);
  assign recv_diff = link.dev_recv_cmd ^ link.host_recv_ack;

  // Bus decode: writes act at the end of their one-cycle data phase
  assign ap       = hsel && hready && htrans[1];
  assign wr       = ap_valid_reg && ap_write_reg;
  assign win_wr   = wr && (ap_addr_reg[7:6] == `WIN_SEND);
  assign do_send  = wr && (ap_addr_reg == `OFF_CTRL) && hwdata[`CTRL_SEND];
  assign do_rdone = wr && (ap_addr_reg == `OFF_CTRL) &&
                    hwdata[`CTRL_RDONE];
  assign rd_clr   = ap && !hwrite && (haddr[7:0] == `OFF_IRQ_STAT);

  // A new request is refused while a response is owed or, if serialised,
  // while the previous confirmation is pending; responses always pass
  assign blocked = !sh_cmd_reg[0] &&
                   (rsp_owed_reg ||
                    (ctrl_reg[`CTRL_SERIAL - 2] &&
                     conf_pend_reg));
  assign send_ok = send_eq &&
                   (len_reg <= `MBX_CAP_BYTES) &&
                   (len_reg >= `MBX_HDR_BYTES) &&
                   (sh_dest_reg == `CHANNEL_TOKEN) &&
                   (sh_src_reg != '0) &&
                   !blocked;
  assign refuse  = (win_wr && !send_eq) || (do_send && !send_ok) ||
                   (do_rdone && !recv_diff);

  // Register read data, taken in the address phase
  always_comb begin
    reg_rdata = '0;
    unique case (haddr[7:0])
      `OFF_CTRL:     reg_rdata = {28'h0, ctrl_reg, 2'h0};
      `OFF_STATUS:   reg_rdata = {26'h0, rsp_owed_reg, conf_pend_reg,
                                  link.host_recv_ack, link.dev_recv_cmd,
                                  link.dev_send_ack, link.host_send_cmd};
      `OFF_LEN:      reg_rdata = len_reg;
      `OFF_IRQ_STAT: reg_rdata = {29'h0, irq_stat_reg};
      `OFF_IRQ_MASK: reg_rdata = {29'h0, irq_mask_reg};
      default:       reg_rdata = '0;
    endcase
  end

  // Address phase capture; held while a read is stretched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= '0;
    end else if (hready) begin
      ap_valid_reg <= ap;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= haddr[7:0];
    end
  end

  // Read path: the mailbox window costs two wait states because
  // the device registers its read port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout    <= 1'b1;
      hrdata       <= '0;
      rd_cnt_reg   <= 2'h0;
      link.rm_addr <= '0;
      rcv_cmd_reg  <= '0;
    end else if (ap && !hwrite && haddr[7:6] == `WIN_RECV) begin
      hreadyout    <= 1'b0;
      rd_cnt_reg   <= `RD_WAIT;
      link.rm_addr <= haddr[5:2];
    end else if (rd_cnt_reg == 2'h1) begin
      hreadyout  <= 1'b1;
      rd_cnt_reg <= 2'h0;
      hrdata     <= recv_diff ? link.rm_rdata : '0;
      if (recv_diff && link.rm_addr == `HDR_CMD) begin
        rcv_cmd_reg <= link.rm_rdata;
      end
    end else if (rd_cnt_reg != 2'h0) begin
      rd_cnt_reg <= rd_cnt_reg - 2'h1;
    end else if (ap && !hwrite) begin
      hrdata <= reg_rdata;
    end
  end

  // Error response is never used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= `CTRL_RST;
      len_reg      <= `LEN_RST;
      irq_mask_reg <= `MASK_RST;
    end else if (wr) begin
      if (ap_addr_reg == `OFF_CTRL) begin
        ctrl_reg <= hwdata[`CTRL_SERIAL:`CTRL_SERVER];
      end
      if (ap_addr_reg == `OFF_LEN) begin
        len_reg <= hwdata;
      end
      if (ap_addr_reg == `OFF_IRQ_MASK) begin
        irq_mask_reg <= hwdata[2:0];
      end
    end
  end

  // Send window: writes pass only while the host owns the box;
  // destination, source and command are shadowed for the checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.sm_we    <= 1'b0;
      link.sm_addr  <= '0;
      link.sm_wdata <= '0;
      sh_dest_reg   <= '0;
      sh_src_reg    <= '0;
      sh_cmd_reg    <= '0;
    end else begin
      link.sm_we <= win_wr && send_eq;
      if (win_wr && send_eq) begin
        link.sm_addr  <= ap_addr_reg[5:2];
        link.sm_wdata <= hwdata;
        if (ap_addr_reg[5:2] == `HDR_DEST) begin
          sh_dest_reg <= hwdata;
        end
        if (ap_addr_reg[5:2] == `HDR_SRC) begin
          sh_src_reg <= hwdata;
        end
        if (ap_addr_reg[5:2] == `HDR_CMD) begin
          sh_cmd_reg <= hwdata;
        end
      end
    end
  end

  // Host flags: the hand-over is the last act of a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.host_send_cmd <= 1'b0;
      link.host_recv_ack <= 1'b0;
    end else begin
      if (do_send && send_ok) begin
        link.host_send_cmd <= ~link.host_send_cmd;
      end
      if (do_rdone && recv_diff) begin
        link.host_recv_ack <= ~link.host_recv_ack;
      end
    end
  end

  // Conversation tracking: odd codes are replies to even requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conf_pend_reg <= 1'b0;
      rsp_owed_reg  <= 1'b0;
    end else begin
      if (do_rdone && recv_diff) begin
        if (rcv_cmd_reg[0]) begin
          conf_pend_reg <= 1'b0;
        end else if (ctrl_reg[`CTRL_SERVER - 2] ||
                     rcv_cmd_reg[1]) begin
          rsp_owed_reg <= 1'b1;
        end
      end
      // Send updates come after receive-done updates so a same-cycle send is not lost
      if (do_send && send_ok) begin
        if (sh_cmd_reg[0]) begin
          rsp_owed_reg <= 1'b0;
        end else begin
          conf_pend_reg <= 1'b1;
        end
      end
    end
  end

  // Edge detectors on ownership changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_eq_prev_reg   <= 1'b1;
      recv_diff_prev_reg <= 1'b0;
    end else begin
      send_eq_prev_reg   <= send_eq;
      recv_diff_prev_reg <= recv_diff;
    end
  end

  assign irq_set[`IRQ_RECV]    = recv_diff && !recv_diff_prev_reg;
  assign irq_set[`IRQ_FREE]    = send_eq && !send_eq_prev_reg;
  assign irq_set[`IRQ_REFUSED] = refuse;

  // Sticky status, cleared by its read; a new event wins the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~{3{rd_clr}}) | irq_set;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // mbx_host_end

// ### verification/mbx_link_checker.sv
/* Concurrent checks on the flags and mailbox ports of the link.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
module mbx_link_checker (
  input logic           hclk,
  input logic           hresetn,
  input logic           host_send_cmd,
  input logic           dev_send_ack,
  input logic           dev_recv_cmd,
  input logic           host_recv_ack,
  input logic           sm_we,
  input mbx_pkg::widx_t sm_addr,
  input mbx_pkg::word_t sm_wdata,
  input mbx_pkg::widx_t rm_addr,
  input mbx_pkg::word_t rm_rdata
);
  import mbx_pkg::*;
  logic s_eq;
  logic r_eq;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Ownership of each box, as the flag pairs tell it
  assign s_eq = host_send_cmd == dev_send_ack;
  assign r_eq = dev_recv_cmd == host_recv_ack;

  a_reset_flags: assert property (
    $rose(hresetn) |-> !(host_send_cmd | dev_send_ack |
                         dev_recv_cmd | host_recv_ack))
    else $error("flag set after reset");
  a_send_owner: assert property (sm_we |-> s_eq)
    else $error("send box written while device owns it");
  a_recv_hidden: assert property (
    r_eq && $past(r_eq) |-> rm_rdata == '0)
    else $error("receive box visible while device owns it");
  a_ack_bound: assert property (
    s_eq ##1 !s_eq |-> ##[1:16] s_eq)
    else $error("device never took the send box");
  a_cmd_step: assert property (
    $changed(host_send_cmd) |-> $past(s_eq))
    else $error("send flag toggled without ownership");
  a_ack_step: assert property (
    $changed(dev_send_ack) |-> !$past(s_eq))
    else $error("send ack toggled without ownership");
  a_rcmd_step: assert property (
    $changed(dev_recv_cmd) |-> $past(r_eq))
    else $error("receive flag toggled without ownership");
  a_rack_step: assert property (
    $changed(host_recv_ack) |-> !$past(r_eq))
    else $error("receive ack toggled without ownership");
  // Main traffic seen at all
  c_send: cover property ($changed(host_send_cmd));
  c_recv: cover property ($changed(dev_recv_cmd));
  c_done: cover property ($changed(host_recv_ack));
  // Command word written by the host and read back on the other box
  c_cmd_write: cover property (sm_we && sm_addr == 4'h7 && !sm_wdata[0]);
  c_cmd_read: cover property (rm_addr == 4'h7 && rm_rdata != '0);
endmodule // mbx_link_checker

// ### verification/dual_port_mailbox_handshake_tb.sv
/* Bench joining host end and device end over the link interface.
   Assumes an AHB-Lite master here and the local task modelled here. */
`timescale 1ns/1ns
module dual_port_mailbox_handshake_tb;
  import mbx_pkg::*;
  logic       hclk, hresetn, hsel, hwrite, hready, irq;
  logic       task_req, task_done, ind_event, ind_ready;
  logic [1:0] htrans;
  logic [2:0] hsize, ind_num;
  logic [31:0] haddr;
  word_t      hwdata, hrdata, rd, mode, task_cmd, task_handle;
  word_t      task_tag, task_data, task_status, task_rsp_handle;
  word_t      task_rsp_tag, ind_cmd;
  int         bad_count, n_checks;
  mbx_link_if link ();
  mbx_host_end i_mbx_host_end (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(), .irq(irq),
    .link(link));
  mbx_dev_end i_mbx_dev_end (.hclk(hclk), .hresetn(hresetn),
    .link(link), .task_req(task_req), .task_cmd(task_cmd),
    .task_handle(task_handle), .task_tag(task_tag),
    .task_data(task_data), .task_done(task_done),
    .task_status(task_status), .task_rsp_handle(task_rsp_handle),
    .task_rsp_tag(task_rsp_tag), .ind_event(ind_event),
    .ind_num(ind_num), .ind_cmd(ind_cmd), .ind_ready(ind_ready));
  mbx_link_checker i_mbx_link_checker (.hclk(hclk), .hresetn(hresetn),
    .host_send_cmd(link.host_send_cmd), .dev_send_ack(link.dev_send_ack),
    .dev_recv_cmd(link.dev_recv_cmd), .host_recv_ack(link.host_recv_ack),
    .sm_we(link.sm_we), .sm_addr(link.sm_addr), .sm_wdata(link.sm_wdata),
    .rm_addr(link.rm_addr), .rm_rdata(link.rm_rdata));

  // Free-running 125 MHz clock
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // Compare and count
  task automatic chk(string n, word_t s, word_t e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Edge-by-edge wait for a level; a hang counts as a mismatch
  task automatic wt(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (s !== 1'b1 && k < 200);
    if (s !== 1'b1) chk("wait", 32'h0, 32'h1);
  endtask
  // One single-word transfer; each phase ends at an edge with hready high
  task automatic bus(int w, logic [7:0] a, word_t d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w[0];
    haddr <= {24'h0, a};
    wt(hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(hready);
    rd = hrdata;
  endtask
  // Receive window word i
  task automatic rx(int i, word_t e);
    bus(0, {2'h2, i[3:0], 2'h0}, '0);
    chk("rx word", rd, e);
  endtask
  // Fill the send box destination, source and command words, length and first data word, then hand over
  task automatic send(word_t c, word_t l, word_t d0, word_t d1, word_t d10);
    bus(1, 8'h40, d0);
    bus(1, 8'h44, d1);
    bus(1, 8'h5C, c);
    bus(1, 8'h68, d10);
    bus(1, 8'h08, l);
    bus(1, 8'h00, mode | 32'h1);
  endtask
  // Local task replies under the router handle it was given
  task automatic reply(word_t s);
    task_status <= s;
    task_rsp_handle <= 32'h00000100;
    task_rsp_tag <= task_tag;
    task_done <= 1'b1;
    @(posedge hclk);
    task_done <= 1'b0;
  endtask

  task automatic t_basic();
    bus(0, 8'h04, '0);
    chk("status", rd, 32'h0);
    bus(1, 8'h10, 32'h1);
    bus(1, 8'h4C, 32'd22);
    bus(1, 8'h54, 32'd7);
    send(32'h10, 32'd44, 32'h20, 32'd444, 32'hA5);
    wt(task_req);
    chk("task cmd", task_cmd, 32'h10);
    chk("handle", task_handle, 32'h100);
    chk("data", task_data, 32'hA5);
    rx(7, 32'h0);
    reply(32'h55);
    wt(irq);
    bus(0, 8'h0C, '0);
    chk("irq stat", rd, 32'h3);
    rx(0, 32'h20);
    rx(1, 32'd444);
    rx(3, 32'd22);
    rx(6, 32'h55);
    rx(7, 32'h11);
    bus(1, 8'h00, 32'h2);
    bus(0, 8'h04, '0);
    chk("status", rd, 32'hF);
    $display("test basic done");
  endtask

  task automatic t_refuse();
    word_t c[3][3] = '{'{68, 32'h20, 444}, '{44, 1, 444}, '{44, 32'h20, 0}};
    for (int i = 0; i < 3; i++) begin
      send(32'h10, c[i][0], c[i][1], c[i][2], 0);
      bus(0, 8'h0C, '0);
      chk("refused", rd, 32'h4);
      bus(0, 8'h04, '0);
      chk("status", rd, 32'hF);
    end
    $display("test refuse done");
  endtask

  task automatic t_serial();
    mode = 32'h8;
    send(32'h10, 32'd44, 32'h20, 32'd444, 32'h1);
    wt(task_req);
    bus(0, 8'h0C, '0);
    bus(1, 8'h00, mode | 32'h1);
    bus(0, 8'h0C, '0);
    chk("serial", rd, 32'h4);
    bus(0, 8'h04, '0);
    chk("status", rd, 32'h1C);
    reply(32'h0);
    wt(irq);
    bus(0, 8'h0C, '0);
    chk("irq stat", rd, 32'h1);
    rx(7, 32'h11);
    mode = 32'h0;
    bus(1, 8'h00, 32'h2);
    $display("test serial done");
  endtask

  task automatic t_ind();
    send(32'hF00, 32'd44, 32'h20, 32'd444, 32'h2);
    wt(irq);
    bus(0, 8'h0C, '0);
    rx(7, 32'hF01);
    bus(1, 8'h00, 32'h2);
    ind_num <= 3'h0;
    ind_cmd <= 32'h32;
    ind_event <= 1'b1;
    @(posedge hclk);
    ind_event <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("no ind", {31'h0, irq}, 32'h0);
    chk("ind ready", {31'h0, ind_ready}, 32'h1);
    ind_num <= 3'h1;
    ind_event <= 1'b1;
    @(posedge hclk);
    ind_event <= 1'b0;
    wt(irq);
    bus(0, 8'h0C, '0);
    rx(0, 32'h20);
    rx(2, 32'h1);
    rx(7, 32'h32);
    bus(1, 8'h00, 32'h2);
    bus(0, 8'h04, '0);
    chk("owed", rd, 32'h23);
    send(32'h10, 32'd44, 32'h20, 32'd444, 32'h0);
    bus(0, 8'h0C, '0);
    chk("refused", rd, 32'h4);
    send(32'h33, 32'd44, 32'h20, 32'd444, 32'h0);
    bus(0, 8'h0C, '0);
    bus(0, 8'h04, '0);
    chk("answered", rd, 32'h0);
    // Server role: an indication whose code asks nothing is still owed
    bus(1, 8'h00, 32'h4);
    ind_cmd <= 32'h30;
    ind_event <= 1'b1;
    @(posedge hclk);
    ind_event <= 1'b0;
    wt(irq);
    bus(0, 8'h0C, '0);
    rx(7, 32'h30);
    bus(1, 8'h00, 32'h6);
    bus(0, 8'h04, '0);
    chk("server owed", rd, 32'h2C);
    $display("test indication done");
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence, with a second reset after the last test
  initial begin
    {hresetn, hsel, hwrite, task_done, ind_event} = '0;
    {haddr, htrans, hwdata, ind_num, ind_cmd, mode} = '0;
    {task_status, task_rsp_handle, task_rsp_tag} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_basic();
    t_refuse();
    t_serial();
    t_ind();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h04, '0);
    chk("status", rd, 32'h0);
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule // dual_port_mailbox_handshake_tb
